// ==== dv/shift_mac_datapath_tb.sv ====
// Purpose: self-checking bench for the shift and accumulate path
// Assumes: memory model answers one cycle after each strobe
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/1ns
`default_nettype none
module shift_mac_datapath_tb;
  import smd_pkg::*;
  logic        mclk_i = 0, resetn_i = 0, instr_valid_i = 0, repeat_prefix_i = 0;
  logic [15:0] instr_word0_i = 0, instr_word1_i = 0, repeat_count_i = 0, op_val = 0;
  logic        dol_ptr7_wr_i = 0, reg_wr_i = 0, reg_rd_i = 0, rd_pend = 0;
  logic [31:0] dol_ptr7_data_i = 0, reg_wdata_i = 0, reg_rdata_o, acc, prod, mult;
  logic [4:0]  reg_addr_i = 0;
  logic [21:0] pm_addr_o;
  logic [15:0] dol_data_i, pm_data_i;
  logic [7:0]  dol_field_o;
  logic [9:0]  look;  // unsupported, ready and operand field one cycle after accept
  logic        instr_ready_o, unsupported_o, busy_o, dol_req_o, pm_rd_o;
  logic        v = 0, c = 0, n = 0, z = 0;
  logic [5:0]  overflow_counter = 0;
  logic [31:0] exp_q[$];
  int          fails = 0, samples_checked = 0;

  smd_datapath smd_datapath_inst (.mclk_i, .resetn_i, .instr_valid_i, .instr_word0_i,
    .instr_word1_i, .repeat_prefix_i, .repeat_count_i, .instr_ready_o, .unsupported_o,
    .busy_o, .dol_req_o, .dol_field_o, .dol_data_i, .dol_ptr7_wr_i, .dol_ptr7_data_i,
    .pm_rd_o, .pm_addr_o, .pm_data_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o);
  smd_mem_model smd_mem_model_inst (.mclk_i, .dol_req_i(dol_req_o), .pm_rd_i(pm_rd_o),
    .pm_addr_i(pm_addr_o), .op_val_i(op_val), .dol_data_o(dol_data_i),
    .pm_data_o(pm_data_i));

  // 250 MHz core clock
  always #2 mclk_i = ~mclk_i;

  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge mclk_i) begin
    if (rd_pend) check(reg_rdata_o, exp_q.pop_front());
    rd_pend <= reg_rd_i;
  end

  // one bus cycle; on a read d is the expected answer
  task automatic bus(input logic w, r, input logic [4:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (r) exp_q.push_back(d);
    @(posedge mclk_i);
  endtask

  // always under the repeat prefix: shifts must ignore it
  task automatic exec(input logic [15:0] w0, w1, input int cnt, output int k);
    instr_valid_i <= 1'b1;
    instr_word0_i <= w0;
    instr_word1_i <= w1;
    repeat_prefix_i <= 1'b1;
    repeat_count_i <= 16'(cnt);
    bus(0, 0, 0, 0);
    instr_valid_i <= 1'b0;
    k = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge mclk_i);
      if (i == 0) look = {unsupported_o, instr_ready_o, dol_field_o};
      if (busy_o !== 1'b1) break;
      k++;
    end
    @(posedge mclk_i);
  endtask

  task automatic shift(input bit pair, input int cnt);
    logic [64:0] r;
    int          k;
    acc = $urandom;
    prod = $urandom;
    mult = $urandom;
    if (pair) mult[21:16] = cnt[5:0];
    else mult[20:16] = cnt[4:0];
    bus(1, 0, REG_ACC, acc);
    bus(1, 0, REG_PROD, prod);
    bus(1, 0, REG_MULT, mult);
    exec(pair ? OP_SHR_PAIR : OP_SHR_LONG, 16'h0, 5, k);
    check(32'(k), 32'h0);
    check(32'(look[9:8]), 32'h1);
    // extra low bit catches the last bit out; zero count leaves it clear
    r = {(pair ? {acc, prod} : {acc, 32'h0}), 1'b0} >> cnt;
    c = pair ? r[0] : r[32];
    acc = r[64:33];
    if (pair) prod = r[32:1];
    z = pair ? (r[64:1] == 0) : (acc == 0);
    n = acc[31];
    bus(0, 1, REG_ACC, acc);
    bus(0, 1, REG_PROD, prod);
    bus(0, 1, REG_STATUS, {18'h0, overflow_counter, 4'h0, v, c, n, z});
    bus(0, 1, REG_RPT, 32'h0);
  endtask

  task automatic mac(input bit imm, inc, pw, input int cnt, pmv, input bit sat,
                     input logic [31:0] a0, p0, input logic [21:0] ad);
    logic [32:0] s;
    logic [31:0] sp, ptr;
    logic [21:0] pa;
    logic [15:0] op;
    int          k;
    acc = a0;
    prod = p0;
    mult = $urandom;
    op = 16'($urandom);
    op_val <= op;
    ptr = {10'h0, ad};
    bus(1, 0, REG_CTRL, {24'h0, 4'(pmv), 2'b0, 1'b1, sat});
    bus(1, 0, REG_ACC, acc);
    bus(1, 0, REG_PROD, prod);
    bus(1, 0, REG_MULT, mult);
    bus(1, 0, REG_PTR7, ptr);
    dol_ptr7_wr_i <= pw;
    dol_ptr7_data_i <= 32'h00123456;
    exec(imm ? {OP_MAC_IMM_HI, 8'h3C} : OP_MAC_PTR_W0,
         imm ? ad[15:0] : {(inc ? OP_MAC_PTR_INC : OP_MAC_PTR_KEEP), 8'h3C}, cnt, k);
    dol_ptr7_wr_i <= 1'b0;
    check(32'(k), 32'(cnt + 2));
    check(32'(look), 32'h03C);
    for (int i = 0; i <= cnt; i++) begin
      if (pmv >= 0) sp = prod << pmv;
      else sp = $signed(prod) >>> (-pmv);
      s = {1'b0, acc} + {1'b0, sp};
      c = s[32];
      if (acc[31] == sp[31] && s[31] != acc[31]) begin
        v = 1'b1;
        if (sat) s[31:0] = acc[31] ? SAT_NEG : SAT_POS;
        else overflow_counter = acc[31] ? overflow_counter - 6'h1 : overflow_counter + 6'h1;
      end
      acc = s[31:0];
      z = (acc == 0);
      n = acc[31];
      pa = imm ? {6'h0, ad[15:0] + 16'(i)} : ad + (inc ? 22'(i) : 22'h0);
      mult[31:16] = op;
      prod = $signed(op) * $signed(pa[15:0] ^ {pa[21:16], 10'h0A5});
    end
    if (!imm) ptr = pw ? 32'h00123456 : ptr + (inc ? 32'(cnt + 1) : 32'h0);
    bus(0, 1, REG_ACC, acc);
    bus(0, 1, REG_PROD, prod);
    bus(0, 1, REG_MULT, mult);
    bus(0, 1, REG_PTR7, ptr);
    bus(0, 1, REG_STATUS, {18'h0, overflow_counter, 4'h0, v, c, n, z});
  endtask

  // *********************************
  // scenarios
  // *********************************
  initial begin
    int cnts[5] = '{0, 1, 31, 32, 63};
    int k;
    void'($urandom(4));
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    bus(0, 1, REG_CTRL, 32'h2);
    bus(0, 1, REG_STATUS, 32'h0);
    bus(0, 1, 5'h1C, 32'h0);
    $display("test reset values done");
    foreach (cnts[i]) begin
      shift(1, cnts[i]);
      shift(0, cnts[i] % 32);
    end
    shift(1, $urandom_range(63));
    shift(0, $urandom_range(31));
    // object mode clear: the pair shift is refused and leaves the accumulator alone
    bus(1, 0, REG_CTRL, 32'h0);
    exec(OP_SHR_PAIR, 16'h0, 0, k);
    check(32'(look[9:8]), 32'h3);
    bus(0, 1, REG_ACC, acc);
    $display("test shifts done");
    mac(1, 0, 0, 2, -5, 0, $urandom, $urandom, 22'h00FFFF);
    mac(0, 1, 0, 3, 2, 0, $urandom, $urandom, 22'h234560);
    mac(0, 0, 0, 1, 0, 1, 32'h7FFFFFF0, 32'h7FFFFFFF, 22'h3FFFF0);
    mac(0, 1, 1, 0, -8, 0, $urandom, $urandom, 22'h2AAAAA);
    mac(1, 0, 0, 0, 0, 0, 32'h80000000, 32'h80000000, 22'h001234);
    mac(1, 0, 0, 0, 0, 1, 32'h80000000, 32'hFFFFFFFF, 22'h000010);
    $display("test accumulate done");
    bus(0, 0, 0, 0);
    bus(0, 0, 0, 0);
    summarize();
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #20000;
    fails++;
    summarize();
  end
endmodule // shift_mac_datapath_tb
`default_nettype wire

// ==== dv/smd_mem_model.sv ====
// Purpose: far-side memory answering operand and coefficient fetches
// Assumes: every answer stands only in the cycle after its strobe
// Notes:   idle lines toggle so a late sample never sees stale data
`timescale 1ns/1ns
`default_nettype none
module smd_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        dol_req_i,
  input  wire logic        pm_rd_i,
  input  wire logic [21:0] pm_addr_i,
  input  wire logic [15:0] op_val_i,
  output logic      [15:0] dol_data_o,
  output logic      [15:0] pm_data_o
);
  // coefficient depends on all 22 address bits, so a stray upper bit shows
  always @(posedge mclk_i) begin
    dol_data_o <= dol_req_i ? op_val_i : ~dol_data_o;
    pm_data_o  <= pm_rd_i ? (pm_addr_i[15:0] ^ {pm_addr_i[21:16], 10'h0A5}) : ~pm_data_o;
  end
endmodule // smd_mem_model
`default_nettype wire

// ==== src/smd_datapath.sv ====
// Purpose: shift and multiply-accumulate execution path with its own register port
// Assumes: instruction, operand and program-memory ports are on mclk_i; read data one cycle later
// Notes:   shifts finish in the accept cycle; accumulate forms are pipelined, one step a cycle
`timescale 1ns/1ns
`default_nettype none

module smd_datapath
  import smd_pkg::*;
#(
  parameter int RPT_WIDTH = RPT_W
) (
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  // instruction stream
  input  wire logic                  instr_valid_i,
  input  wire logic [15:0]           instr_word0_i,
  input  wire logic [15:0]           instr_word1_i,
  input  wire logic                  repeat_prefix_i,
  input  wire logic [RPT_WIDTH-1:0]  repeat_count_i,
  output logic                       instr_ready_o,
  output logic                       unsupported_o,
  output logic                       busy_o,
  // data operand fetch through the addressing unit
  output logic                       dol_req_o,
  output logic [7:0]                 dol_field_o,
  input  wire logic [15:0]           dol_data_i,
  input  wire logic                  dol_ptr7_wr_i,
  input  wire logic [31:0]           dol_ptr7_data_i,
  // program memory coefficient fetch
  output logic                       pm_rd_o,
  output logic [PM_ADDR_W-1:0]       pm_addr_o,
  input  wire logic [15:0]           pm_data_i,
  // register port
  input  wire logic [REG_AW-1:0]     reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o
);

  typedef enum logic [0:0] {ST_IDLE, ST_MAC} smd_state_t;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // last bit dropped by a right shift; zero count drops nothing
  function automatic logic last_out(input logic [63:0] v, input logic [5:0] n);
    logic [63:0] s;
    s = v >> (n - 6'd1);
    return (n == 6'd0) ? 1'b0 : s[0];
  endfunction

  // product scaled by the signed shift mode
  function automatic logic [31:0] scale_prod(input logic [31:0] p, input logic signed [3:0] pm);
    logic [3:0] amt;
    amt = pm[3] ? 4'(-pm) : 4'(pm);
    return pm[3] ? 32'($signed(p) >>> amt) : (p << amt);
  endfunction

  // ***************************************************************
  // architectural state
  // ***************************************************************
  smd_state_t            state_q;
  logic [31:0]           acc_q;
  logic [31:0]           prod_q;
  logic [31:0]           mult_q;
  logic [31:0]           ptr7_q;
  smd_flags_t            flags_q;
  logic [OVC_W-1:0]      ovc_q;
  smd_ctrl_t             ctrl_q;
  logic [RPT_WIDTH-1:0]  repeat_counter_q;
  logic                  fetch_done_q;
  logic                  exec_pend_q;
  logic                  form_ptr_q;
  logic                  ptr_inc_q;
  logic [PMA_W-1:0]      pma_q;
  logic [7:0]            dol_field_q;
  logic                  unsupported_q;
  logic [31:0]           rdata_q;

  // ***************************************************************
  // decode
  // ***************************************************************
  logic is_pair, is_long, is_mac_imm, is_mac_ptr, is_shift, is_mac, accept, fetch_now, exec_now;
  logic mac_last, wr_ok;

  assign is_pair    = (instr_word0_i == OP_SHR_PAIR) && ctrl_q.obj;
  assign is_long    = (instr_word0_i == OP_SHR_LONG) && ctrl_q.obj;
  assign is_mac_imm = (instr_word0_i[15:8] == OP_MAC_IMM_HI);
  assign is_mac_ptr = (instr_word0_i == OP_MAC_PTR_W0) && ctrl_q.obj &&
                      ((instr_word1_i[15:8] == OP_MAC_PTR_KEEP) ||
                       (instr_word1_i[15:8] == OP_MAC_PTR_INC));
  assign is_shift   = is_pair || is_long;
  assign is_mac     = is_mac_imm || is_mac_ptr;

  // register writes and a new instruction never meet in one cycle
  assign instr_ready_o = (state_q == ST_IDLE) && !reg_wr_i;
  assign accept        = instr_valid_i && instr_ready_o;
  assign busy_o        = (state_q == ST_MAC);
  assign fetch_now     = (state_q == ST_MAC) && !fetch_done_q;
  assign exec_now      = (state_q == ST_MAC) && exec_pend_q;
  assign mac_last      = exec_now && fetch_done_q;
  assign wr_ok         = reg_wr_i && (state_q == ST_IDLE);

  // fetch strobes decode the sequencer flops only, addresses come from flops
  assign dol_req_o   = fetch_now;
  assign pm_rd_o     = fetch_now;
  assign dol_field_o = dol_field_q;
  assign pm_addr_o   = form_ptr_q ? ptr7_q[PM_ADDR_W-1:0]
                                  : {{PMA_HI_W{1'b0}}, pma_q};

  // ***************************************************************
  // shift results, count taken from the register as it stands
  // ***************************************************************
  logic [PAIR_CNT_W-1:0] pair_cnt;
  logic [LONG_CNT_W-1:0] long_cnt;
  logic [63:0]           pair_res;
  logic [31:0]           long_res;

  assign pair_cnt = mult_q[CNT_LSB +: PAIR_CNT_W];
  assign long_cnt = mult_q[CNT_LSB +: LONG_CNT_W];
  assign pair_res = {acc_q, prod_q} >> pair_cnt;
  assign long_res = acc_q >> long_cnt;

  // ***************************************************************
  // accumulate step
  // ***************************************************************
  logic [31:0] prod_sh, acc_new, sum_res;
  logic [32:0] sum33;
  logic        pos_ovf, neg_ovf;

  // add first, then clamp; zero and sign flags look at the final accumulator, carry at the raw sum
  always_comb begin
    prod_sh = scale_prod(prod_q, ctrl_q.pm);
    sum33   = {1'b0, acc_q} + {1'b0, prod_sh};
    sum_res = sum33[31:0];
    pos_ovf = !acc_q[31] && !prod_sh[31] && sum_res[31];
    neg_ovf = acc_q[31] && prod_sh[31] && !sum_res[31];
    if (ctrl_q.sat && pos_ovf) begin
      acc_new = SAT_POS;
    end else if (ctrl_q.sat && neg_ovf) begin
      acc_new = SAT_NEG;
    end else begin
      acc_new = sum_res;
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // one fetch per repetition, then one cycle to retire the last step: n+2 in all
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= ST_IDLE;
      fetch_done_q <= 1'b0;
      exec_pend_q  <= 1'b0;
    end else begin
      exec_pend_q <= fetch_now;
      if (accept && is_mac) begin
        state_q      <= ST_MAC;
        fetch_done_q <= 1'b0;
      end else if (mac_last) begin
        state_q <= ST_IDLE;
      end else if (fetch_now && (repeat_counter_q == '0)) begin
        fetch_done_q <= 1'b1;
      end
    end
  end

  // repeat counter: loaded for accumulate, cleared by shifts, counts down per fetch
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      repeat_counter_q <= '0;
    end else if (accept && is_shift) begin
      repeat_counter_q <= '0;
    end else if (accept && is_mac) begin
      repeat_counter_q <= repeat_prefix_i ? repeat_count_i : '0;
    end else if (fetch_now && (repeat_counter_q != '0)) begin
      repeat_counter_q <= repeat_counter_q - 1'b1;
    end else if (accept && repeat_prefix_i) begin
      repeat_counter_q <= '0;  // an unknown opcode does not keep a stale count
    end
  end

  // operand form, field and immediate coefficient address
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      form_ptr_q  <= 1'b0;
      ptr_inc_q   <= 1'b0;
      pma_q       <= '0;
      dol_field_q <= 8'h00;
    end else if (accept && is_mac) begin
      form_ptr_q  <= is_mac_ptr;
      ptr_inc_q   <= is_mac_ptr && (instr_word1_i[15:8] == OP_MAC_PTR_INC);
      pma_q       <= instr_word1_i;
      dol_field_q <= is_mac_ptr ? instr_word1_i[7:0] : instr_word0_i[7:0];
    end else if (fetch_now && !form_ptr_q) begin
      pma_q <= pma_q + 1'b1;  // wraps inside the low window, never leaves it
    end
  end

  // unknown opcodes are consumed and reported for one cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unsupported_q <= 1'b0;
    end else begin
      unsupported_q <= accept && !is_shift && !is_mac;
    end
  end
  assign unsupported_o = unsupported_q;

  // ***************************************************************
  // accumulator, product, multiplicand, flags
  // ***************************************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q   <= '0;
      prod_q  <= '0;
      mult_q  <= '0;
      flags_q <= FLAGS_RST;
    end else if (wr_ok && (reg_addr_i == REG_ACC)) begin
      acc_q <= reg_wdata_i;
    end else if (wr_ok && (reg_addr_i == REG_PROD)) begin
      prod_q <= reg_wdata_i;
    end else if (wr_ok && (reg_addr_i == REG_MULT)) begin
      mult_q <= reg_wdata_i;
    end else if (wr_ok && (reg_addr_i == REG_STATUS)) begin
      flags_q <= reg_wdata_i[STAT_FLAG_LSB +: 4];
    end else if (accept && is_pair) begin
      {acc_q, prod_q} <= pair_res;
      flags_q.c <= last_out({acc_q, prod_q}, pair_cnt);
      flags_q.n <= pair_res[63];
      flags_q.z <= (pair_res == 64'h0);
    end else if (accept && is_long) begin
      acc_q     <= long_res;
      flags_q.c <= last_out({32'h0, acc_q}, {1'b0, long_cnt});
      flags_q.n <= long_res[31];
      flags_q.z <= (long_res == 32'h0);
    end else if (exec_now) begin
      acc_q     <= acc_new;
      mult_q    <= {dol_data_i, mult_q[15:0]};
      prod_q    <= 32'($signed(dol_data_i) * $signed(pm_data_i));
      flags_q.z <= (acc_new == 32'h0);
      flags_q.n <= acc_new[31];
      flags_q.c <= sum33[32];
      if (pos_ovf || neg_ovf) begin
        flags_q.v <= 1'b1;  // sticky across repetitions
      end
    end
  end

  // overflow counter only moves while saturation is off
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovc_q <= '0;
    end else if (wr_ok && (reg_addr_i == REG_STATUS)) begin
      ovc_q <= reg_wdata_i[STAT_OVC_LSB +: OVC_W];
    end else if (exec_now && !ctrl_q.sat && pos_ovf) begin
      ovc_q <= ovc_q + 1'b1;
    end else if (exec_now && !ctrl_q.sat && neg_ovf) begin
      ovc_q <= ovc_q - 1'b1;
    end
  end

  // pointer seven: the operand field's own update beats the post-increment
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr7_q <= '0;
    end else if (wr_ok && (reg_addr_i == REG_PTR7)) begin
      ptr7_q <= reg_wdata_i;
    end else if (fetch_now && dol_ptr7_wr_i) begin
      ptr7_q <= dol_ptr7_data_i;
    end else if (fetch_now && ptr_inc_q) begin
      ptr7_q <= ptr7_q + 32'h1;
    end
  end

  // mode bits
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ok && (reg_addr_i == REG_CTRL)) begin
      ctrl_q      <= reg_wdata_i[CTRL_LSB +: 8];
      ctrl_q.rsvd <= 2'h0;
    end
  end

  // ***************************************************************
  // register read port
  // ***************************************************************
  // reads are served even while busy; unmapped offsets read zero
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_ACC:    rdata_q <= acc_q;
        REG_PROD:   rdata_q <= prod_q;
        REG_MULT:   rdata_q <= mult_q;
        REG_PTR7:   rdata_q <= ptr7_q;
        REG_STATUS: rdata_q <= 32'({ovc_q, 4'h0, flags_q});
        REG_CTRL:   rdata_q <= 32'(ctrl_q);
        REG_RPT:    rdata_q <= 32'(repeat_counter_q);
        default:    rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata_o = rdata_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [RPT_WIDTH:0]   run_len_q;
  logic [RPT_WIDTH-1:0] n_q;

  // cycles spent in the accumulate run, checked against the loaded count
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_len_q <= '0;
      n_q       <= '0;
    end else if (accept && is_mac) begin
      run_len_q <= '0;
      n_q       <= repeat_prefix_i ? repeat_count_i : '0;
    end else if (busy_o) begin
      run_len_q <= run_len_q + 1'b1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_pair_zero_cnt;
    accept && is_pair && (pair_cnt == '0);
  endsequence

  a_pair_carry_zero: assert property (s_pair_zero_cnt |=> !flags_q.c)
    else $error("pair shift by zero left carry set");
  a_pair_shift_value: assert property (accept && is_pair && !wr_ok |=>
      ({acc_q, prod_q} == ($past({acc_q, prod_q}) >> $past(pair_cnt))))
    else $error("pair shift result wrong");
  a_pair_neg_zero: assert property (accept && is_pair |=>
      (flags_q.n == acc_q[31]) && (flags_q.z == ({acc_q, prod_q} == 64'h0)))
    else $error("pair shift flags wrong");
  a_long_shift_value: assert property (accept && is_long |=>
      (acc_q == ($past(acc_q) >> $past(long_cnt))) && (flags_q.z == (acc_q == 32'h0)))
    else $error("long shift result or zero flag wrong");
  a_long_carry_zero: assert property (accept && is_long && (long_cnt == '0) |=>
      !flags_q.c)
    else $error("long shift by zero left carry set");
  a_shift_rpt_clear: assert property (accept && is_shift |=> (repeat_counter_q == '0) && !busy_o)
    else $error("shift did not clear repeat counter");
  a_mac_run_length: assert property (mac_last |-> (run_len_q == ({1'b0, n_q} + 1'b1)))
    else $error("accumulate run length not count plus two");
  a_imm_addr_window: assert property (pm_rd_o && !form_ptr_q |->
      (pm_addr_o[PM_ADDR_W-1:PMA_W] == '0))
    else $error("immediate coefficient address above low window");
  a_imm_addr_step: assert property (pm_rd_o && !form_ptr_q ##1 pm_rd_o |->
      (pm_addr_o[PMA_W-1:0] == ($past(pm_addr_o[PMA_W-1:0]) + 16'h1)))
    else $error("immediate coefficient address did not step by one");
  a_sat_clamp: assert property (exec_now && ctrl_q.sat && pos_ovf |=> acc_q == SAT_POS)
    else $error("positive overflow not clamped");
  a_neg_clamp: assert property (exec_now && ctrl_q.sat && neg_ovf |=>
      (acc_q == SAT_NEG))
    else $error("negative overflow not clamped");
  a_ovc_count_down: assert property (exec_now && !ctrl_q.sat && neg_ovf |=>
      (ovc_q == $past(ovc_q) - 1'b1))
    else $error("overflow counter did not count down");
  a_ovf_sticky: assert property (flags_q.v && !wr_ok |=> flags_q.v)
    else $error("overflow flag cleared by datapath");
  a_ptr7_priority: assert property (fetch_now && dol_ptr7_wr_i && !wr_ok |=>
      (ptr7_q == $past(dol_ptr7_data_i)))
    else $error("operand update of pointer seven lost");

endmodule : smd_datapath

`default_nettype wire

// ==== src/smd_pkg.sv ====
// Purpose: constants, field layouts and carrier types of the shift and multiply-accumulate path
// Assumes: one core clock, registers reached over a plain address/strobe port
package smd_pkg;

  // ***************************************************************
  // instruction encodings
  // ***************************************************************
  localparam logic [15:0] OP_SHR_PAIR     = 16'h565B;
  localparam logic [15:0] OP_SHR_LONG     = 16'h5622;
  localparam logic [15:0] OP_MAC_PTR_W0   = 16'h5607;
  localparam logic [7:0]  OP_MAC_IMM_HI   = 8'h14;
  localparam logic [7:0]  OP_MAC_PTR_KEEP = 8'hC7;
  localparam logic [7:0]  OP_MAC_PTR_INC  = 8'h87;

  // ***************************************************************
  // datapath widths and values
  // ***************************************************************
  localparam int          CNT_LSB    = 16;  // shift count sits in the upper half
  localparam int          PAIR_CNT_W = 6;
  localparam int          LONG_CNT_W = 5;
  localparam int          PM_ADDR_W  = 22;
  localparam int          PMA_W      = 16;
  localparam int          PMA_HI_W   = PM_ADDR_W - PMA_W;
  localparam int          OVC_W      = 6;
  localparam int          RPT_W      = 16;
  localparam logic [31:0] SAT_POS    = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG    = 32'h80000000;

  // ***************************************************************
  // register map (byte offsets) and field positions
  // ***************************************************************
  localparam int         REG_AW        = 5;
  localparam logic [4:0] REG_ACC       = 5'h00;
  localparam logic [4:0] REG_PROD      = 5'h04;
  localparam logic [4:0] REG_MULT      = 5'h08;
  localparam logic [4:0] REG_PTR7      = 5'h0C;
  localparam logic [4:0] REG_STATUS    = 5'h10;
  localparam logic [4:0] REG_CTRL      = 5'h14;
  localparam logic [4:0] REG_RPT       = 5'h18;
  localparam int         STAT_FLAG_LSB = 0;
  localparam int         STAT_OVC_LSB  = 8;
  localparam int         CTRL_LSB      = 0;

  typedef struct packed {
    logic v;
    logic c;
    logic n;
    logic z;
  } smd_flags_t;

  typedef struct packed {
    logic signed [3:0] pm;    // product shift mode, signed amount
    logic [1:0]        rsvd;
    logic              obj;   // object mode bit
    logic              sat;   // saturation mode bit
  } smd_ctrl_t;

  localparam smd_flags_t FLAGS_RST = '0;
  localparam smd_ctrl_t  CTRL_RST  = '{pm: 4'sh0, rsvd: 2'h0, obj: 1'b1, sat: 1'b0};

endpackage : smd_pkg
